// >>> msscr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: interrupt sources, external pins, normal memory pad drive
module msscr_pin_model (
  // clock
  input  wire logic              aclk,
  // requests from the bench
  input  wire logic              fire,
  input  wire logic [23:0]       fire_mask,
  input  wire logic [3:0]        pin_lvl,
  // towards the block
  output logic [23:0]            ext_irq_event,
  output msscr_pkg::msscr_pins_s pins_in,
  output msscr_pkg::msscr_pads_s mc_pads
);
  logic [23:0] ev_r  = 24'h00_0000;
  logic [31:0] cnt_r = 32'h0000_0000;

  // detection logic reports each event as a one-cycle pulse
  always_ff @(posedge aclk) begin
    ev_r <= fire ? fire_mask : 24'h00_0000;
  end

  always_ff @(posedge aclk) begin
    cnt_r <= cnt_r + 32'h0000_0001;
  end

  assign ext_irq_event = ev_r;
  assign pins_in       = msscr_pkg::msscr_pins_s'(pin_lvl);
  // pattern changes every cycle so a stale pad value cannot pass
  assign mc_pads = msscr_pkg::msscr_pads_s'({cnt_r[6:0], ~cnt_r, cnt_r});
endmodule // msscr_pin_model
`default_nettype wire

// >>> msscr_pkg.sv
// Functional notes
// - pending flags 4..23 at bits 4..23; write 1 clears; bits 3:0 zero.
// - snapshot bits 3..0: wait, nand config, ready/busy, battery fault.
// - reset cause bit 2 marks watchdog boot; write 1 clears it.
// - reset cause bit 1 marks wakeup-from-sleep boot; write 1 clears it.
// - cause bit 0 marks power-on boot; reset value 0x1; write 1 clears.
// - both scratch registers cleared by power-on only, kept otherwise.
// - strength a bit 31 low enables programmed strengths, high disables.
// - strength a: address 9:8, data lanes 3..0 below; 30:10 reserved.
// - strength b holds memory clock 1 and 0 fields at 29:28 and 27:26.
// - strength b: clock enable, strobes, nand, byte, wr/rd, selects.
// - in sleep data bus floats when bit 11 is 0, driven 0 when 1.
// - in sleep wait bit 10 and ready bit 9 stay inputs or drive 0.
// - in sleep nand controls drive 11100 if bit 8 clear, else float.
// - in sleep bits 7..0 pick inactive level or float per pin group.
`default_nettype none
package msscr_pkg;

  localparam logic [31:0] OFS_PEND     = 32'h5600_00a8;
  localparam logic [31:0] OFS_PINS     = 32'h5600_00ac;
  localparam logic [31:0] OFS_PARTID   = 32'h5600_00b0;
  localparam logic [31:0] OFS_CAUSE    = 32'h5600_00b4;
  localparam logic [31:0] OFS_SCR_A    = 32'h5600_00b8;
  localparam logic [31:0] OFS_SCR_B    = 32'h5600_00bc;
  localparam logic [31:0] OFS_DRV_A    = 32'h5600_00c4;
  localparam logic [31:0] OFS_DRV_B    = 32'h5600_00c8;
  localparam logic [31:0] OFS_SLEEP    = 32'h5600_00cc;
  localparam logic [31:0] OFS_IRQ_STAT = 32'h5600_00d0;
  localparam logic [31:0] OFS_IRQ_CLR  = 32'h5600_00d4;
  localparam logic [31:0] OFS_IRQ_EN   = 32'h5600_00d8;

  // register select indices
  localparam int SEL_N = 12;
  localparam int S_PEND = 0;
  localparam int S_PINS = 1;
  localparam int S_PARTID = 2;
  localparam int S_CAUSE = 3;
  localparam int S_SCR_A = 4;
  localparam int S_SCR_B = 5;
  localparam int S_DRV_A = 6;
  localparam int S_DRV_B = 7;
  localparam int S_SLEEP = 8;
  localparam int S_ISTAT = 9;
  localparam int S_ICLR = 10;
  localparam int S_IEN = 11;

  localparam logic [31:0] PEND_MASK   = 32'h00ff_fff0;
  localparam logic [31:0] DRV_A_MASK  = 32'h8000_03ff;
  localparam logic [31:0] DRV_B_MASK  = 32'h3fff_ffff;
  localparam logic [31:0] SLEEP_MASK  = 32'h0000_0fff;
  localparam logic [2:0]  CAUSE_POR   = 3'h1;
  localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
  localparam int          CAUSE_WDT_B = 2;
  localparam int          CAUSE_WAK_B = 1;
  localparam logic [4:0]  NAND_IDLE   = 5'h1c;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic bus_wait_in;
    logic nand_config_pin;
    logic flash_ready_busy;
    logic battery_fault_pin;
  } msscr_pins_s;

  typedef struct packed {
    logic            strength_ctrl_disable;
    logic [20:0]     rsvd;
    logic [1:0]      addr_bus_strength;
    logic [3:0][1:0] data_lane_strength;
  } msscr_drv_a_s;

  typedef struct packed {
    logic [1:0]      rsvd;
    logic [1:0]      mem_clk1_strength;
    logic [1:0]      mem_clk0_strength;
    logic [1:0]      mem_clk_en_strength;
    logic [1:0]      strobe_strength;
    logic [1:0]      nand_ctrl_strength;
    logic [1:0]      byte_en_strength;
    logic [1:0]      wr_rd_en_strength;
    logic [7:0][1:0] chip_sel_strength;
  } msscr_drv_b_s;

  // nand_o order: chip en, read en, write en, address latch, command latch
  typedef struct packed {
    logic [31:0] data_o;
    logic        data_oe_n;
    logic        wait_o;
    logic        wait_oe_n;
    logic        rdy_o;
    logic        rdy_oe_n;
    logic [4:0]  nand_o;
    logic        nand_oe_n;
    logic [1:0]  strobe_o;
    logic        strobe_oe_n;
    logic [3:0]  bmask_o;
    logic        bmask_oe_n;
    logic        oe_o;
    logic        oe_oe_n;
    logic        we_o;
    logic        we_oe_n;
    logic [7:0]  cs_o;
    logic [7:0]  cs_oe_n;
  } msscr_pads_s;

endpackage
`default_nettype wire

// >>> msscr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module msscr_regs #(
  parameter int          ADDR_W  = 32,
  parameter logic [31:0] PART_ID = 32'h0000_0a5a  // arbitrary value
) (
  // clock, resets, enable
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   por_n,
  input  wire logic                   ce,
  // boot cause levels from the reset controller
  input  wire logic                   boot_cause_wdt,
  input  wire logic                   boot_cause_wake,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]      awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [ADDR_W-1:0]      araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  // interrupt events and output
  input  wire logic [23:0]            ext_irq_event,
  output logic                        irq,
  // pins and strength fields
  input  wire msscr_pkg::msscr_pins_s pins_in,
  output msscr_pkg::msscr_drv_a_s     drv_a,
  output msscr_pkg::msscr_drv_b_s     drv_b,
  // sleep control of memory pads
  input  wire logic                   sleep_req,
  input  wire msscr_pkg::msscr_pads_s mc_pads,
  output msscr_pkg::msscr_pads_s      pads
);

  if (ADDR_W != 32) begin : g_chk
    $error("msscr_regs: ADDR_W must be 32");
  end

  function automatic logic [msscr_pkg::SEL_N-1:0] decode(
    input logic [ADDR_W-1:0] a);
    logic [msscr_pkg::SEL_N-1:0] s;
    s = '0;
    if (a == msscr_pkg::OFS_PEND) s[msscr_pkg::S_PEND] = 1'b1;
    else if (a == msscr_pkg::OFS_PINS) s[msscr_pkg::S_PINS] = 1'b1;
    else if (a == msscr_pkg::OFS_PARTID) s[msscr_pkg::S_PARTID] = 1'b1;
    else if (a == msscr_pkg::OFS_CAUSE) s[msscr_pkg::S_CAUSE] = 1'b1;
    else if (a == msscr_pkg::OFS_SCR_A) s[msscr_pkg::S_SCR_A] = 1'b1;
    else if (a == msscr_pkg::OFS_SCR_B) s[msscr_pkg::S_SCR_B] = 1'b1;
    else if (a == msscr_pkg::OFS_DRV_A) s[msscr_pkg::S_DRV_A] = 1'b1;
    else if (a == msscr_pkg::OFS_DRV_B) s[msscr_pkg::S_DRV_B] = 1'b1;
    else if (a == msscr_pkg::OFS_SLEEP) s[msscr_pkg::S_SLEEP] = 1'b1;
    else if (a == msscr_pkg::OFS_IRQ_STAT) s[msscr_pkg::S_ISTAT] = 1'b1;
    else if (a == msscr_pkg::OFS_IRQ_CLR) s[msscr_pkg::S_ICLR] = 1'b1;
    else if (a == msscr_pkg::OFS_IRQ_EN) s[msscr_pkg::S_IEN] = 1'b1;
    return s;
  endfunction

  logic [ADDR_W-1:0]           aw_addr_r;
  logic                        aw_have_r;
  logic [31:0]                 w_data_r;
  logic [3:0]                  w_strb_r;
  logic                        w_have_r;
  logic                        bvalid_r;
  logic [1:0]                  bresp_r;
  logic                        rvalid_r;
  logic [1:0]                  rresp_r;
  logic [31:0]                 rdata_r;
  logic                        wr_go;
  logic [msscr_pkg::SEL_N-1:0] wsel;
  logic [msscr_pkg::SEL_N-1:0] rsel;
  logic [31:0]                 wm;
  logic [31:0]                 wd;
  logic [31:0]                 pend_r;
  logic [31:0]                 pend_set;
  logic [31:0]                 pend_clr;
  logic [2:0]                  cause_r;
  logic [31:0]                 scr_a_r;
  logic [31:0]                 scr_b_r;
  logic [31:0]                 drv_a_r;
  logic [31:0]                 drv_b_r;
  logic [11:0]                 slp_r;
  logic [31:0]                 istat_r;
  logic [31:0]                 ien_r;
  logic [31:0]                 istat_clr;
  logic [3:0]                  pin_s1_r;
  logic [3:0]                  pin_s2_r;
  logic [3:0]                  pin_s3_r;
  logic [3:0]                  snap_r;
  msscr_pkg::msscr_pads_s      slp_pads;
  msscr_pkg::msscr_pads_s      pads_r;
  logic [31:0]                 rd_nxt;

  // bus handshake
  assign awready = ce && !aw_have_r && !bvalid_r;
  assign wready  = ce && !w_have_r && !bvalid_r;
  assign arready = ce && !rvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;
  assign wr_go   = ce && aw_have_r && w_have_r;
  assign wsel    = decode(aw_addr_r);
  assign rsel    = decode(araddr);
  assign wm      = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                    {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign wd      = w_data_r & wm;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_have_r  <= 1'b0;
      w_data_r  <= msscr_pkg::RST_ZERO;
      w_strb_r  <= 4'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= msscr_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (|wsel) ? msscr_pkg::RESP_OKAY : msscr_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_nxt = msscr_pkg::RST_ZERO;
    if (rsel[msscr_pkg::S_PEND]) rd_nxt = pend_r;
    else if (rsel[msscr_pkg::S_PINS]) rd_nxt = {28'h000_0000, snap_r};
    else if (rsel[msscr_pkg::S_PARTID]) rd_nxt = PART_ID;
    else if (rsel[msscr_pkg::S_CAUSE]) rd_nxt = {29'h0000_0000, cause_r};
    else if (rsel[msscr_pkg::S_SCR_A]) rd_nxt = scr_a_r;
    else if (rsel[msscr_pkg::S_SCR_B]) rd_nxt = scr_b_r;
    else if (rsel[msscr_pkg::S_DRV_A]) rd_nxt = drv_a_r;
    else if (rsel[msscr_pkg::S_DRV_B]) rd_nxt = drv_b_r;
    else if (rsel[msscr_pkg::S_SLEEP]) rd_nxt = {20'h0_0000, slp_r};
    else if (rsel[msscr_pkg::S_ISTAT]) rd_nxt = istat_r;
    else if (rsel[msscr_pkg::S_IEN]) rd_nxt = ien_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= msscr_pkg::RESP_OKAY;
      rdata_r  <= msscr_pkg::RST_ZERO;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_nxt;
        rresp_r  <= (|rsel) ? msscr_pkg::RESP_OKAY : msscr_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // pending flags: a same-cycle event wins over the clear
  assign pend_set = {8'h00, ext_irq_event} & msscr_pkg::PEND_MASK;
  assign pend_clr = (wr_go && wsel[msscr_pkg::S_PEND]) ?
                    (wd & msscr_pkg::PEND_MASK) : msscr_pkg::RST_ZERO;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_r <= msscr_pkg::RST_ZERO;
    end else if (ce) begin
      pend_r <= (pend_r & ~pend_clr) | pend_set;
    end
  end

  // boot cause: power-on forces 001; other resets add their cause
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      cause_r <= msscr_pkg::CAUSE_POR;
    end else if (!aresetn) begin
      if (boot_cause_wdt) cause_r[msscr_pkg::CAUSE_WDT_B] <= 1'b1;
      if (boot_cause_wake) cause_r[msscr_pkg::CAUSE_WAK_B] <= 1'b1;
    end else if (ce && wr_go && wsel[msscr_pkg::S_CAUSE]) begin
      cause_r <= cause_r & ~wd[2:0];
    end
  end

  // scratch survives every reset but power-on
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      scr_a_r <= msscr_pkg::RST_ZERO;
      scr_b_r <= msscr_pkg::RST_ZERO;
    end else if (aresetn && ce && wr_go) begin
      if (wsel[msscr_pkg::S_SCR_A]) scr_a_r <= (scr_a_r & ~wm) | wd;
      if (wsel[msscr_pkg::S_SCR_B]) scr_b_r <= (scr_b_r & ~wm) | wd;
    end
  end

  // strength and sleep control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drv_a_r <= msscr_pkg::RST_ZERO;
      drv_b_r <= msscr_pkg::RST_ZERO;
      slp_r   <= 12'h000;
    end else if (ce && wr_go) begin
      if (wsel[msscr_pkg::S_DRV_A])
        drv_a_r <= (drv_a_r & ~(wm & msscr_pkg::DRV_A_MASK)) |
                   (wd & msscr_pkg::DRV_A_MASK);
      if (wsel[msscr_pkg::S_DRV_B])
        drv_b_r <= (drv_b_r & ~(wm & msscr_pkg::DRV_B_MASK)) |
                   (wd & msscr_pkg::DRV_B_MASK);
      if (wsel[msscr_pkg::S_SLEEP])
        slp_r <= (slp_r & ~wm[11:0]) | wd[11:0];
    end
  end

  assign drv_a = msscr_pkg::msscr_drv_a_s'(drv_a_r);
  assign drv_b = msscr_pkg::msscr_drv_b_s'(drv_b_r);

  // interrupt status, clear and enable
  assign istat_clr = (wr_go && wsel[msscr_pkg::S_ICLR]) ?
                     wd : msscr_pkg::RST_ZERO;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_r <= msscr_pkg::RST_ZERO;
      ien_r   <= msscr_pkg::RST_ZERO;
    end else if (ce) begin
      istat_r <= (istat_r & ~istat_clr) | pend_set;
      if (wr_go && wsel[msscr_pkg::S_IEN])
        ien_r <= ((ien_r & ~wm) | wd) & msscr_pkg::PEND_MASK;
    end
  end

  assign irq = |(istat_r & ien_r);

  // pin snapshot through three stages, taken when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      pin_s3_r <= 4'h0;
      snap_r   <= 4'h0;
    end else if (ce) begin
      pin_s1_r <= pins_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r) snap_r <= pin_s3_r;
    end
  end

  // sleep pad states
  always_comb begin
    slp_pads             = mc_pads;
    slp_pads.data_o      = 32'h0000_0000;
    slp_pads.data_oe_n   = ~slp_r[11];
    slp_pads.wait_o      = 1'b0;
    slp_pads.wait_oe_n   = ~slp_r[10];
    slp_pads.rdy_o       = 1'b0;
    slp_pads.rdy_oe_n    = ~slp_r[9];
    slp_pads.nand_o      = msscr_pkg::NAND_IDLE;
    slp_pads.nand_oe_n   = slp_r[8];
    slp_pads.strobe_o    = 2'h3;
    slp_pads.strobe_oe_n = slp_r[7];
    slp_pads.bmask_o     = 4'hf;
    slp_pads.bmask_oe_n  = slp_r[6];
    slp_pads.oe_o        = 1'b1;
    slp_pads.oe_oe_n     = slp_r[5];
    slp_pads.we_o        = 1'b1;
    slp_pads.we_oe_n     = slp_r[4];
    slp_pads.cs_o        = 8'hff;
    slp_pads.cs_oe_n     = {slp_r[0], slp_r[1], {5{slp_r[2]}}, slp_r[3]};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pads_r <= mc_pads;
    end else if (ce) begin
      pads_r <= sleep_req ? slp_pads : mc_pads;
    end
  end

  assign pads = pads_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pend_set_wins: assert property ((ce && |pend_set) |=>
    ((pend_r & $past(pend_set)) == $past(pend_set)))
    else $error("pending event lost");
  a_pend_w1c: assert property ((ce && |(pend_clr & ~pend_set)) |=>
    ((pend_r & $past(pend_clr & ~pend_set)) == 32'h0000_0000))
    else $error("pending flag not cleared");
  a_pend_rsvd_zero: assert property (pend_r[3:0] == 4'h0)
    else $error("reserved pending bits set");
  a_snap_stable: assert property ((ce && pin_s2_r == pin_s3_r) |=>
    (snap_r == $past(pin_s3_r)))
    else $error("pin snapshot wrong");
  a_por_cause: assert property (@(posedge aclk) disable iff (1'b0)
    (!por_n) |=> (cause_r == 3'h1))
    else $error("power-on cause not set");
  a_scratch_keep: assert property (@(posedge aclk)
    disable iff (!por_n)
    (!aresetn) |=> (scr_a_r == $past(scr_a_r) && scr_b_r == $past(scr_b_r)))
    else $error("scratch lost over reset");
  a_sleep_data: assert property ((ce && sleep_req) |=>
    (pads_r.data_oe_n == !$past(slp_r[11]) && pads_r.data_o == 32'h0000_0000))
    else $error("sleep data bus state wrong");
  a_sleep_nand: assert property (ce && sleep_req && !slp_r[8] |=>
    (pads_r.nand_o == 5'h1c && !pads_r.nand_oe_n))
    else $error("sleep nand pattern wrong");
  a_wake_resume: assert property ((ce && !sleep_req) |=>
    (pads_r == $past(mc_pads)))
    else $error("normal pad control not resumed");
  a_strength_dis: assert property (
    (ce && wr_go && wsel[msscr_pkg::S_DRV_A] && wm[31]) |=>
    (drv_a.strength_ctrl_disable == $past(wd[31])))
    else $error("strength disable bit not stored");

endmodule // msscr_regs
`default_nettype wire

// >>> msscr_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module msscr_regs_bench;
  localparam logic [31:0] PID = 32'h0000_5a5a;  // arbitrary value

  logic                   aclk = 1'b0;
  logic                   aresetn = 1'b0;
  logic                   por_n = 1'b0;
  logic                   wdt = 1'b0;
  logic                   wake = 1'b0;
  logic [31:0]            awaddr = 32'h0000_0000;
  logic                   awvalid = 1'b0;
  logic                   awready;
  logic [31:0]            wdata = 32'h0000_0000;
  logic [3:0]             wstrb = 4'hf;
  logic                   wvalid = 1'b0;
  logic                   wready;
  logic                   ce = 1'b1;
  logic [1:0]             last_bresp = 2'h0;
  logic [1:0]             bresp;
  logic                   bvalid;
  logic                   bready = 1'b0;
  logic [31:0]            araddr = 32'h0000_0000;
  logic                   arvalid = 1'b0;
  logic                   arready;
  logic [31:0]            rdata;
  logic [1:0]             rresp;
  logic                   rvalid;
  logic                   rready = 1'b0;
  logic [23:0]            ev;
  logic                   irq;
  logic                   fire = 1'b0;
  logic [23:0]            fire_mask = 24'h00_0000;
  logic [3:0]             pin_lvl = 4'h0;
  logic                   sleep_req = 1'b0;
  msscr_pkg::msscr_pins_s pins_in;
  msscr_pkg::msscr_drv_a_s drv_a;
  msscr_pkg::msscr_drv_b_s drv_b;
  msscr_pkg::msscr_pads_s mc_pads;
  msscr_pkg::msscr_pads_s pads;
  int                     errors = 0;
  int                     checked = 0;

  always #10 aclk = ~aclk;

  msscr_regs #(.PART_ID(PID)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .por_n(por_n), .ce(ce),
    .boot_cause_wdt(wdt), .boot_cause_wake(wake),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ext_irq_event(ev), .irq(irq), .pins_in(pins_in),
    .drv_a(drv_a), .drv_b(drv_b), .sleep_req(sleep_req),
    .mc_pads(mc_pads), .pads(pads)
  );

  msscr_pin_model i_model (
    .aclk(aclk), .fire(fire), .fire_mask(fire_mask), .pin_lvl(pin_lvl),
    .ext_irq_event(ev), .pins_in(pins_in), .mc_pads(mc_pads)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bit ta;
    bit tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    last_bresp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, msscr_pkg::RESP_OKAY});
  endtask

  task automatic boot(input bit p, input bit w, input bit k);
    @(posedge aclk);
    aresetn <= 1'b0;
    por_n <= !p;
    wdt <= w;
    wake <= k;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    wdt <= 1'b0;
    wake <= 1'b0;
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rchk(msscr_pkg::OFS_PEND, 32'h0000_0000);
    rchk(msscr_pkg::OFS_CAUSE, 32'h0000_0001);
    rchk(msscr_pkg::OFS_SCR_B, 32'h0000_0000);
    rchk(msscr_pkg::OFS_DRV_A, 32'h0000_0000);
    rchk(msscr_pkg::OFS_DRV_B, 32'h0000_0000);
    rchk(msscr_pkg::OFS_SLEEP, 32'h0000_0000);
    wr(msscr_pkg::OFS_PARTID, 32'hffff_ffff);
    chk({30'h0, last_bresp}, {30'h0, msscr_pkg::RESP_OKAY});
    rchk(msscr_pkg::OFS_PARTID, PID);
    rd(32'h5600_00c0, d, r);
    chk(d, 32'h0000_0000);
    chk({30'h0, r}, {30'h0, msscr_pkg::RESP_SLVERR});
    wr(32'h5600_00c0, 32'hffff_ffff);
    chk({30'h0, last_bresp}, {30'h0, msscr_pkg::RESP_SLVERR});
    $display("test reset done");
  endtask

  task automatic pulse(input logic [23:0] m);
    @(posedge aclk);
    fire <= 1'b1;
    fire_mask <= m;
    @(posedge aclk);
    fire <= 1'b0;
  endtask

  task automatic t_events;
    pulse(24'hff_ffff);
    rchk(msscr_pkg::OFS_PEND, 32'h00ff_fff0);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(msscr_pkg::OFS_PEND, 32'h0000_00f0);
    rchk(msscr_pkg::OFS_PEND, 32'h00ff_ff00);
    wr(msscr_pkg::OFS_PEND, 32'h0000_0000);
    rchk(msscr_pkg::OFS_PEND, 32'h00ff_ff00);
    wr(msscr_pkg::OFS_IRQ_EN, 32'h0000_0010);
    chk({31'h0, irq}, 32'h0000_0001);
    rchk(msscr_pkg::OFS_IRQ_CLR, 32'h0000_0000);
    wr(msscr_pkg::OFS_IRQ_CLR, 32'h0000_0010);
    chk({31'h0, irq}, 32'h0000_0000);
    rchk(msscr_pkg::OFS_IRQ_STAT, 32'h00ff_ffe0);
    pulse(24'h00_0010);
    rchk(msscr_pkg::OFS_IRQ_STAT, 32'h00ff_fff0);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(msscr_pkg::OFS_IRQ_EN, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    // an event while the block is frozen must not be recorded
    ce <= 1'b0;
    pulse(24'h00_0020);
    @(posedge aclk);
    chk({31'h0, awready}, 32'h0000_0000);
    ce <= 1'b1;
    rchk(msscr_pkg::OFS_PEND, 32'h00ff_ff10);
    $display("test events done");
  endtask

  task automatic t_cause;
    wr(msscr_pkg::OFS_SCR_A, 32'h1234_5678);
    wr(msscr_pkg::OFS_SCR_B, 32'h9abc_def0);
    wstrb <= 4'h1;
    wr(msscr_pkg::OFS_SCR_A, 32'hffff_ffff);
    wstrb <= 4'hf;
    wr(msscr_pkg::OFS_CAUSE, 32'h0000_0001);
    rchk(msscr_pkg::OFS_CAUSE, 32'h0000_0000);
    boot(1'b0, 1'b1, 1'b0);
    rchk(msscr_pkg::OFS_CAUSE, 32'h0000_0004);
    rchk(msscr_pkg::OFS_SCR_A, 32'h1234_56ff);
    wr(msscr_pkg::OFS_CAUSE, 32'h0000_0004);
    rchk(msscr_pkg::OFS_CAUSE, 32'h0000_0000);
    boot(1'b0, 1'b0, 1'b1);
    rchk(msscr_pkg::OFS_CAUSE, 32'h0000_0002);
    rchk(msscr_pkg::OFS_SCR_B, 32'h9abc_def0);
    wr(msscr_pkg::OFS_CAUSE, 32'h0000_0002);
    rchk(msscr_pkg::OFS_CAUSE, 32'h0000_0000);
    boot(1'b1, 1'b0, 1'b0);
    rchk(msscr_pkg::OFS_CAUSE, 32'h0000_0001);
    rchk(msscr_pkg::OFS_SCR_A, 32'h0000_0000);
    $display("test cause done");
  endtask

  task automatic t_drive;
    wr(msscr_pkg::OFS_DRV_A, 32'hffff_ffff);
    rchk(msscr_pkg::OFS_DRV_A, 32'h8000_03ff);
    chk(drv_a, 32'h8000_03ff);
    wr(msscr_pkg::OFS_DRV_B, 32'hffff_ffff);
    rchk(msscr_pkg::OFS_DRV_B, 32'h3fff_ffff);
    chk(drv_b, 32'h3fff_ffff);
    wr(msscr_pkg::OFS_DRV_A, 32'h0000_0155);
    chk(drv_a, 32'h0000_0155);
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      pin_lvl <= 4'h1 << i;
      repeat (6) @(posedge aclk);
      rchk(msscr_pkg::OFS_PINS, 32'h0000_0001 << i);
    end
    $display("test drive and pins done");
  endtask

  task automatic t_sleep;
    logic [11:0] c[4] = '{12'h000, 12'hfff, 12'h0a5, 12'h05a};
    logic [7:0]  eo[4] = '{8'he0, 8'h1f, 8'hea, 8'he5};
    logic [7:0]  ec[4] = '{8'h00, 8'hff, 8'hbe, 8'h41};
    msscr_pkg::msscr_pads_s m;
    logic [7:0]  oen;
    for (int i = 0; i < 4; i++) begin
      wr(msscr_pkg::OFS_SLEEP, {20'h0_0000, c[i]});
      @(posedge aclk);
      sleep_req <= 1'b1;
      repeat (2) @(posedge aclk);
      oen = {pads.data_oe_n, pads.wait_oe_n, pads.rdy_oe_n, pads.nand_oe_n,
             pads.strobe_oe_n, pads.bmask_oe_n, pads.oe_oe_n, pads.we_oe_n};
      chk({29'h0, oen[7:5]}, {29'h0, eo[i][7:5]});
      chk({27'h0, oen[4:0]}, {27'h0, eo[i][4:0]});
      chk({24'h0, pads.cs_oe_n}, {24'h0, ec[i]});
      if (i == 0) begin
        chk({27'h0, pads.nand_o}, 32'h0000_001c);
        chk({24'h0, pads.cs_o}, 32'h0000_00ff);
        oen = {pads.strobe_o, pads.bmask_o, pads.oe_o, pads.we_o};
        chk({24'h0, oen}, 32'h0000_00ff);
      end
      if (i == 1) begin
        chk(pads.data_o, 32'h0000_0000);
        chk({30'h0, pads.wait_o, pads.rdy_o}, 32'h0000_0000);
      end
      @(posedge aclk);
      sleep_req <= 1'b0;
      @(negedge aclk);
      m = mc_pads;
      @(negedge aclk);
      chk({31'h0, pads === m}, 32'h0000_0001);
    end
    $display("test sleep done");
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    t_reset();
    t_events();
    t_cause();
    t_drive();
    t_sleep();
    final_report();
  end

  // cuts a hang short well beyond the expected run length
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    $display("Error at %0t ns: watchdog expired", $time);
    final_report();
  end
endmodule // msscr_regs_bench
`default_nettype wire
